/* src/phy_startup_pkg.sv */
package phy_startup_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned RST_MIN_NS    = 1000;
  localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned POR_NS        = 2000;
  localparam int unsigned POR_CYC       = (POR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned REF_LOSS_NS   = 2000;
  localparam int unsigned REF_LOSS_CYC  = (REF_LOSS_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned LOCK_EDGES    = 16;
  localparam int unsigned SLOW_HALF_CYC = 8;

  localparam logic [7:0] LINK_IDLE         = 8'h00;
  localparam logic [1:0] REG_LEVEL_DEFAULT = 2'h0;

  typedef enum logic [2:0] {
    ST_OFF      = 3'h0,
    ST_HOLD     = 3'h1,
    ST_LOCK     = 3'h3,
    ST_WAIT_STP = 3'h2,
    ST_RUN      = 3'h6,
    ST_LOWPWR   = 3'h7
  } phase_t;

  typedef struct packed {
    logic ref_clk;
    logic rst_n;
    logic stop;
    logic core;
    logic analog;
    logic io;
    logic bus;
  } pin_in_t;

  typedef struct packed {
    logic       dir;
    logic       data_oe;
    logic [7:0] data;
  } link_out_t;

endpackage

/* src/bit_sync.sv */
`timescale 1ns/1ns
module bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // The first stage feeds only the second one, so a metastable sample settles unseen.
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* src/phy_startup.sv */
// How it works
// R1 - Direction stays high until PLL locks.
// R2 - Only reference clock rising edges count.
// R3 - Output clock derived from reference, phase free; the code divides clk, not the reference.
// R4 - Late reference clock delays start equally.
// R5 - Reset pin low blocks start-up.
// R6 - Link stops reference only after last write.
// R7 - Stop wakes device from low power.
// R8 - Lost reference drops lock, output clock slows.
// R9 - Start needs power-on reset and pin high.
// R10 - Reset low one microsecond restores defaults.
// R11 - Core supply cycling restores register defaults.
// R12 - Link always drives the reset pin.
// R13 - Link holds reset until core supply stable.
// R14 - Link may hold reset while not ready.
// R15 - Core on, reset low means standby.
// R16 - Analog circuits off without core supply.
// R17 - Hosts should enable automatic wake signalling.
// R18 - Link interface survives bus supply removal.
// R19 - Link parks device until bus returns.
// R20 - UART mode regulator level from select field.
// R21 - Drive idle data while direction is high; in ST_LOWPWR data_oe stays low and the data bus is not driven.
// R22 - Stop held high keeps direction high.
// R23 - Link drives idle after direction falls.
// R24 - Reset pin may release asynchronously.
// R25 - Reset release synchronised before state machines.
`timescale 1ns/1ns
module phy_startup (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       reference_clock_in,
  input  wire logic       hardware_reset_n,
  input  wire logic       link_stop,
  input  wire logic       core_supply,
  input  wire logic       analog_supply,
  input  wire logic       io_supply,
  input  wire logic       bus_supply,
  input  wire logic       low_power_request,
  input  wire logic       uart_mode,
  input  wire logic [1:0] regulator_level_select,
  output logic            link_dir,
  output logic            link_data_oe,
  output logic      [7:0] link_data_out,
  output logic            phy_output_clock,
  output logic            pll_locked,
  output logic            regs_default,
  output logic            powered_off,
  output logic            standby,
  output logic            analog_enable,
  output logic            bus_supply_status,
  output logic      [1:0] regulator_level
);

  phy_startup_pkg::pin_in_t pins_raw;
  phy_startup_pkg::pin_in_t pins_s;

  assign pins_raw = '{ref_clk: reference_clock_in, rst_n: hardware_reset_n, stop: link_stop,
                      core: core_supply, analog: analog_supply, io: io_supply,
                      bus: bus_supply};

  // Every pin except low_power_request, uart_mode and regulator_level_select, the reset pin among them, is resynchronised before use.
  bit_sync #(
    .WIDTH ($bits(phy_startup_pkg::pin_in_t))
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (pins_raw),
    .q       (pins_s)
  ); // see R25 see R24

  // Edge detection and filters.
  logic       ref_prev_r;
  logic       ref_prev_nxt;
  logic       ref_rise;
  logic [7:0] idle_cnt_r;
  logic [7:0] idle_cnt_nxt;
  logic       ref_lost;
  logic [7:0] rst_low_cnt_r;
  logic [7:0] rst_low_cnt_nxt;
  logic       reset_asserted_r;
  logic       reset_asserted_nxt;
  logic [7:0] por_cnt_r;
  logic [7:0] por_cnt_nxt;
  logic       por_ok_r;
  logic       por_ok_nxt;

  assign ref_rise = pins_s.ref_clk & ~ref_prev_r; // see R2
  assign ref_lost = (idle_cnt_r == 8'(phy_startup_pkg::REF_LOSS_CYC));

  always_comb begin
    ref_prev_nxt       = pins_s.ref_clk;
    idle_cnt_nxt       = idle_cnt_r;
    rst_low_cnt_nxt    = rst_low_cnt_r;
    reset_asserted_nxt = reset_asserted_r;
    por_cnt_nxt        = por_cnt_r;
    por_ok_nxt         = por_ok_r;
    if (ref_rise) begin
      idle_cnt_nxt = 8'h00;
    end else if (!ref_lost) begin
      idle_cnt_nxt = idle_cnt_r + 8'h01;
    end
    // A low pulse shorter than the minimum is ignored; a long one sets reset_asserted_r, holding start-up off with regs_default high.
    if (pins_s.rst_n) begin
      rst_low_cnt_nxt    = 8'h00;
      reset_asserted_nxt = 1'b0;
    end else if (rst_low_cnt_r == 8'(phy_startup_pkg::RST_MIN_CYC - 1)) begin
      reset_asserted_nxt = 1'b1; // see R10
    end else begin
      rst_low_cnt_nxt = rst_low_cnt_r + 8'h01;
    end
    if (!pins_s.core) begin
      por_cnt_nxt = 8'h00;
      por_ok_nxt  = 1'b0;
    end else if (por_cnt_r == 8'(phy_startup_pkg::POR_CYC)) begin
      por_ok_nxt = 1'b1;
    end else begin
      por_cnt_nxt = por_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_prev_r       <= 1'b0;
      idle_cnt_r       <= 8'h00;
      rst_low_cnt_r    <= 8'h00;
      reset_asserted_r <= 1'b1;
      por_cnt_r        <= 8'h00;
      por_ok_r         <= 1'b0;
    end else begin
      ref_prev_r       <= ref_prev_nxt;
      idle_cnt_r       <= idle_cnt_nxt;
      rst_low_cnt_r    <= rst_low_cnt_nxt;
      reset_asserted_r <= reset_asserted_nxt;
      por_cnt_r        <= por_cnt_nxt;
      por_ok_r         <= por_ok_nxt;
    end
  end

  // Start-up sequence and PLL model.
  phy_startup_pkg::phase_t state_r;
  phy_startup_pkg::phase_t state_nxt;
  logic       pll_locked_r;
  logic       pll_locked_nxt;
  logic [7:0] lock_cnt_r;
  logic [7:0] lock_cnt_nxt;

  always_comb begin
    state_nxt      = state_r;
    pll_locked_nxt = pll_locked_r;
    lock_cnt_nxt   = lock_cnt_r;
    if (!pins_s.core) begin
      state_nxt = phy_startup_pkg::ST_OFF; // see R11
    end else if (!por_ok_r || reset_asserted_r || !pins_s.io) begin
      state_nxt = phy_startup_pkg::ST_HOLD; // see R5 see R9
    end else begin
      case (state_r)
        phy_startup_pkg::ST_OFF, phy_startup_pkg::ST_HOLD: begin
          state_nxt = phy_startup_pkg::ST_LOCK;
        end
        phy_startup_pkg::ST_LOCK: begin
          if (pll_locked_r) begin
            state_nxt = phy_startup_pkg::ST_WAIT_STP; // see R1
          end
        end
        phy_startup_pkg::ST_WAIT_STP: begin
          // A lock lost while waiting must not hand the bus over unlocked.
          if (!pll_locked_r) begin
            state_nxt = phy_startup_pkg::ST_LOCK; // see R1
          end else if (!pins_s.stop) begin
            state_nxt = phy_startup_pkg::ST_RUN; // see R22
          end
        end
        phy_startup_pkg::ST_RUN: begin
          // Loss of bus supply does not stop the link; only the link parks the device.
          if (low_power_request) begin
            state_nxt = phy_startup_pkg::ST_LOWPWR; // see R18
          end
        end
        phy_startup_pkg::ST_LOWPWR: begin
          if (pins_s.stop) begin
            state_nxt = phy_startup_pkg::ST_LOCK; // see R7
          end
        end
        default: begin
          state_nxt = phy_startup_pkg::ST_OFF;
        end
      endcase
    end
    // Lock counts reference edges, so a late reference delays start by the same amount.
    if (state_nxt == phy_startup_pkg::ST_LOCK && !pll_locked_r) begin
      if (lock_cnt_r == 8'(phy_startup_pkg::LOCK_EDGES)) begin
        pll_locked_nxt = 1'b1; // see R4
      end else if (ref_rise) begin
        lock_cnt_nxt = lock_cnt_r + 8'h01;
      end
    end else if (state_nxt == phy_startup_pkg::ST_OFF || state_nxt == phy_startup_pkg::ST_HOLD
                 || state_nxt == phy_startup_pkg::ST_LOWPWR || ref_lost) begin
      // The reference may be stopped in low power, so lock is given up on entry.
      pll_locked_nxt = 1'b0; // see R8
      lock_cnt_nxt   = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r      <= phy_startup_pkg::ST_OFF;
      pll_locked_r <= 1'b0;
      lock_cnt_r   <= 8'h00;
    end else begin
      state_r      <= state_nxt;
      pll_locked_r <= pll_locked_nxt;
      lock_cnt_r   <= lock_cnt_nxt;
    end
  end

  // Link pins and regs_default, registered from the next state so they align with it; other status outputs are registered from the pins.
  phy_startup_pkg::link_out_t link_r;
  phy_startup_pkg::link_out_t link_nxt;
  logic       clk_out_r;
  logic       clk_out_nxt;
  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic       regs_default_r;
  logic       powered_off_r;
  logic       standby_r;
  logic       analog_enable_r;
  logic       bus_status_r;
  logic [1:0] regulator_level_r;
  logic       clk_run;
  logic [7:0] half_cyc;

  assign clk_run  = (state_r == phy_startup_pkg::ST_WAIT_STP) ||
                    (state_r == phy_startup_pkg::ST_RUN);
  // Without lock in ST_RUN the output clock falls to its slowest rate instead of stopping.
  assign half_cyc = pll_locked_r ? 8'h01 : 8'(phy_startup_pkg::SLOW_HALF_CYC); // see R8

  always_comb begin
    link_nxt.dir     = (state_nxt == phy_startup_pkg::ST_LOCK) ||
                       (state_nxt == phy_startup_pkg::ST_WAIT_STP) ||
                       (state_nxt == phy_startup_pkg::ST_LOWPWR); // see R1 see R22
    link_nxt.data_oe = (state_nxt == phy_startup_pkg::ST_LOCK) ||
                       (state_nxt == phy_startup_pkg::ST_WAIT_STP);
    link_nxt.data    = phy_startup_pkg::LINK_IDLE; // see R21
    clk_out_nxt      = clk_out_r;
    div_cnt_nxt      = 8'h00;
    if (clk_run) begin
      if (div_cnt_r + 8'h01 >= half_cyc) begin
        clk_out_nxt = ~clk_out_r; // see R3
      end else begin
        div_cnt_nxt = div_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_r            <= '{dir: 1'b0, data_oe: 1'b0, data: phy_startup_pkg::LINK_IDLE};
      clk_out_r         <= 1'b0;
      div_cnt_r         <= 8'h00;
      regs_default_r    <= 1'b1;
      powered_off_r     <= 1'b1;
      standby_r         <= 1'b0;
      analog_enable_r   <= 1'b0;
      bus_status_r      <= 1'b0;
      regulator_level_r <= phy_startup_pkg::REG_LEVEL_DEFAULT;
    end else begin
      link_r            <= link_nxt;
      clk_out_r         <= clk_out_nxt;
      div_cnt_r         <= div_cnt_nxt;
      regs_default_r    <= (state_nxt == phy_startup_pkg::ST_OFF) ||
                           (state_nxt == phy_startup_pkg::ST_HOLD); // see R10 see R11
      powered_off_r     <= !pins_s.core && !pins_s.analog && reset_asserted_r; // see R15
      standby_r         <= pins_s.core && reset_asserted_r; // see R15
      analog_enable_r   <= pins_s.core && pins_s.analog; // see R16
      bus_status_r      <= pins_s.bus; // see R18
      regulator_level_r <= uart_mode ? regulator_level_select
                                     : phy_startup_pkg::REG_LEVEL_DEFAULT; // see R20
    end
  end

  assign link_dir          = link_r.dir;
  assign link_data_oe      = link_r.data_oe;
  assign link_data_out     = link_r.data;
  assign phy_output_clock  = clk_out_r;
  assign pll_locked        = pll_locked_r;
  assign regs_default      = regs_default_r;
  assign powered_off       = powered_off_r;
  assign standby           = standby_r;
  assign analog_enable     = analog_enable_r;
  assign bus_supply_status = bus_status_r;
  assign regulator_level   = regulator_level_r;

  chk_dir_fall_lock: assert property (@(posedge clk) disable iff (sys_rst) // see R1
    $fell(link_r.dir) && state_r == phy_startup_pkg::ST_RUN |-> $past(pll_locked_r)
  ) else $error("Direction fell without PLL lock.");
  chk_idle_data: assert property (@(posedge clk) disable iff (sys_rst) // see R21
    link_r.dir && link_r.data_oe |-> link_r.data == phy_startup_pkg::LINK_IDLE
  ) else $error("Data bus not idle while direction is high.");
  chk_stop_holds_dir: assert property (@(posedge clk) disable iff (sys_rst) // see R22
    state_r == phy_startup_pkg::ST_WAIT_STP && pins_s.stop && !reset_asserted_r && pins_s.core
    && pins_s.io && pll_locked_r |=> link_r.dir && state_r == phy_startup_pkg::ST_WAIT_STP
  ) else $error("Direction dropped while stop held high.");
  chk_reset_blocks: assert property (@(posedge clk) disable iff (sys_rst) // see R5
    reset_asserted_r |=> !link_r.dir && regs_default_r
  ) else $error("Device started while reset pin held low.");
  chk_start_needs_both: assert property (@(posedge clk) disable iff (sys_rst) // see R9
    $past(state_r) == phy_startup_pkg::ST_HOLD && state_r == phy_startup_pkg::ST_LOCK
    |-> $past(por_ok_r) && !$past(reset_asserted_r)
  ) else $error("Left reset without both reset sources released.");
  chk_reset_min_width: assert property (@(posedge clk) disable iff (sys_rst) // see R10
    $rose(reset_asserted_r) |-> !$past(pins_s.rst_n, 1) && !$past(pins_s.rst_n, 8)
                                && !$past(pins_s.rst_n, 19)
  ) else $error("Reset taken from a pulse shorter than the minimum.");
  chk_core_off_defaults: assert property (@(posedge clk) disable iff (sys_rst) // see R11
    !pins_s.core |=> regs_default_r && state_r == phy_startup_pkg::ST_OFF
  ) else $error("Registers not at defaults with core supply off.");
  chk_analog_gated: assert property (@(posedge clk) disable iff (sys_rst) // see R16
    !pins_s.core |=> !analog_enable_r
  ) else $error("Analog circuits enabled without core supply.");
  chk_regulator_level: assert property (@(posedge clk) disable iff (sys_rst) // see R20
    uart_mode |=> regulator_level_r == $past(regulator_level_select)
  ) else $error("Regulator level does not follow the select field.");
  chk_lost_ref_unlock: assert property (@(posedge clk) disable iff (sys_rst) // see R8
    ref_lost && !ref_rise |=> !pll_locked_r
  ) else $error("PLL stayed locked without a reference clock.");
  chk_clock_gated: assert property (@(posedge clk) disable iff (sys_rst) // see R3
    !clk_run |=> $stable(clk_out_r)
  ) else $error("Output clock toggled before start-up.");
  chk_lock_edges: assert property (@(posedge clk) disable iff (sys_rst) // see R4
    $rose(pll_locked_r) |-> $past(lock_cnt_r) == 8'(phy_startup_pkg::LOCK_EDGES)
  ) else $error("PLL locked before the required reference edges.");
  chk_wake_on_stop: assert property (@(posedge clk) disable iff (sys_rst) // see R7
    state_r == phy_startup_pkg::ST_LOWPWR && pins_s.stop && pins_s.core && por_ok_r
    && !reset_asserted_r && pins_s.io |=> state_r == phy_startup_pkg::ST_LOCK
  ) else $error("Stop did not wake the device from low power.");

endmodule

/* tb/link_partner.sv */
`timescale 1ns/1ns
module link_partner #(
  parameter int unsigned REF_HALF_NS = 200
) (
  input  wire logic ref_run,
  input  wire logic hold_reset,
  input  wire logic stop_req,
  output logic      reference_clock_in,
  output logic      hardware_reset_n,
  output logic      link_stop
);
  // The reset pin is always driven, never left floating.
  assign hardware_reset_n = !hold_reset;
  // Stop follows stop_req as driven; this side does not hold it low once direction falls.
  assign link_stop = stop_req;
  // Free-running, unrelated in phase to clk; it stands low while stopped.
  initial begin
    reference_clock_in = 1'b0;
    #7;
    forever begin
      #(REF_HALF_NS);
      reference_clock_in = ref_run ? !reference_clock_in : 1'b0;
    end
  end
endmodule

/* tb/phy_startup_tb.sv */
`timescale 1ns/1ns
module phy_startup_tb;
  logic       clk;
  logic       sys_rst;
  logic       ref_run;
  logic       hold_reset;
  logic       stop_req;
  logic       ref_clk;
  logic       rst_n;
  logic       stop;
  logic       core;
  logic       analog;
  logic       io;
  logic       bus;
  logic       lpr;
  logic       uart;
  logic [1:0] sel;
  logic       dir;
  logic       oe;
  logic [7:0] data;
  logic       oclk;
  logic       lock;
  logic       rdef;
  logic       poff;
  logic       stby;
  logic       aen;
  logic       bstat;
  logic [1:0] rlev;
  int         bad_count;
  int         n_tests;

  link_partner i_partner (
    .ref_run(ref_run), .hold_reset(hold_reset), .stop_req(stop_req),
    .reference_clock_in(ref_clk), .hardware_reset_n(rst_n), .link_stop(stop));

  phy_startup i_dut (
    .clk(clk), .sys_rst(sys_rst), .reference_clock_in(ref_clk),
    .hardware_reset_n(rst_n), .link_stop(stop), .core_supply(core),
    .analog_supply(analog), .io_supply(io), .bus_supply(bus),
    .low_power_request(lpr), .uart_mode(uart), .regulator_level_select(sel),
    .link_dir(dir), .link_data_oe(oe), .link_data_out(data),
    .phy_output_clock(oclk), .pll_locked(lock), .regs_default(rdef),
    .powered_off(poff), .standby(stby), .analog_enable(aen),
    .bus_supply_status(bstat), .regulator_level(rlev));

  always #25 clk = !clk;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return dir;
      1: return lock;
      default: return oe;
    endcase
  endfunction

  // Bounded wait; a miss shows up as a mismatch in the final compare.
  task automatic wait_for(input int s, input logic v, input int maxc, input string nm);
    for (int i = 0; i < maxc; i++) begin
      if (pick(s) === v) break;
      cyc(1);
    end
    check(nm, {7'h00, pick(s)}, {7'h00, v});
  endtask

  task automatic restart();
    hold_reset = 1'b1;
    cyc(30);
    check("regs_default", {7'h00, rdef}, 8'h01);
    check("dir_in_reset", {7'h00, dir}, 8'h00);
    hold_reset = 1'b0;
    wait_for(0, 1'b1, 60, "dir_up");
    wait_for(1, 1'b1, 300, "lock");
    wait_for(0, 1'b0, 10, "dir_down");
  endtask

  task automatic t_power_states();
    cyc(5);
    check("powered_off", {7'h00, poff}, 8'h01);
    analog = 1'b1;
    cyc(5);
    check("analog_en_nocore", {7'h00, aen}, 8'h00);
    core = 1'b1;
    io = 1'b1;
    cyc(5);
    check("standby", {7'h00, stby}, 8'h01);
    check("analog_en", {7'h00, aen}, 8'h01);
    ref_run = 1'b1;
    cyc(200);
    check("dir_held_reset", {7'h00, dir}, 8'h00);
    ref_run = 1'b0;
  endtask

  task automatic t_late_ref();
    hold_reset = 1'b0;
    wait_for(0, 1'b1, 60, "dir_up");
    check("oe_up", {7'h00, oe}, 8'h01);
    check("idle_data", data, 8'h00);
    cyc(150);
    check("no_lock_no_ref", {7'h00, lock}, 8'h00);
    check("dir_until_lock", {7'h00, dir}, 8'h01);
    ref_run = 1'b1;
    wait_for(1, 1'b1, 200, "lock_late");
    wait_for(0, 1'b0, 10, "dir_down");
    check("oe_down", {7'h00, oe}, 8'h00);
    begin
      logic a;
      a = oclk;
      cyc(1);
      check("out_clock_toggles", {7'h00, oclk}, {7'h00, !a});
    end
  endtask

  task automatic t_stop_hold();
    stop_req = 1'b1;
    hold_reset = 1'b1;
    cyc(30);
    hold_reset = 1'b0;
    wait_for(1, 1'b1, 300, "lock_stop");
    cyc(50);
    check("dir_stop_high", {7'h00, dir}, 8'h01);
    stop_req = 1'b0;
    wait_for(0, 1'b0, 10, "dir_after_stop");
  endtask

  task automatic t_short_pulse();
    hold_reset = 1'b1;
    cyc(10);
    hold_reset = 1'b0;
    cyc(10);
    check("short_dir", {7'h00, dir}, 8'h00);
    check("short_lock", {7'h00, lock}, 8'h01);
    check("short_defaults", {7'h00, rdef}, 8'h00);
  endtask

  task automatic t_ref_loss();
    ref_run = 1'b0;
    wait_for(1, 1'b0, 60, "lock_lost");
    ref_run = 1'b1;
    restart();
  endtask

  task automatic t_low_power();
    lpr = 1'b1;
    wait_for(0, 1'b1, 10, "lp_dir");
    check("lp_oe", {7'h00, oe}, 8'h00);
    check("lp_unlocked", {7'h00, lock}, 8'h00);
    lpr = 1'b0;
    ref_run = 1'b0;
    cyc(20);
    stop_req = 1'b1;
    ref_run = 1'b1;
    wait_for(2, 1'b1, 10, "wake_oe");
    wait_for(1, 1'b1, 200, "wake_lock");
    stop_req = 1'b0;
    wait_for(0, 1'b0, 10, "wake_run");
  endtask

  task automatic t_bus_and_uart();
    bus = 1'b0;
    cyc(10);
    check("bus_status", {7'h00, bstat}, 8'h00);
    check("bus_gone_dir", {7'h00, dir}, 8'h00);
    check("bus_gone_lock", {7'h00, lock}, 8'h01);
    lpr = 1'b1;
    wait_for(0, 1'b1, 10, "bus_gone_park");
    lpr = 1'b0;
    bus = 1'b1;
    cyc(4);
    check("bus_back", {7'h00, bstat}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      uart = 1'b1;
      sel = 2'(i);
      cyc(2);
      check("reg_level", {6'h00, rlev}, 8'(i));
    end
    uart = 1'b0;
    cyc(2);
    check("reg_level_off", {6'h00, rlev}, 8'h00);
  endtask

  task automatic t_core_cycle();
    core = 1'b0;
    cyc(5);
    check("core_defaults", {7'h00, rdef}, 8'h01);
    check("core_dir", {7'h00, dir}, 8'h00);
  endtask

  task automatic finish_test();
    $display("Mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end

  initial begin
    {clk, ref_run, stop_req, core, analog, io, lpr, uart} = '0;
    {sel, bus, hold_reset, sys_rst} = {2'h0, 1'b1, 1'b1, 1'b1};
    bad_count = 0;
    n_tests = 0;
    cyc(12);
    sys_rst = 1'b0;
    t_power_states();
    t_late_ref();
    t_stop_hold();
    t_short_pulse();
    t_ref_loss();
    t_low_power();
    t_bus_and_uart();
    t_core_cycle();
    finish_test();
  end
endmodule
